// ==== ufsm_top.sv ====
// ufsm_top: user-side layer 1 maintenance state machine with primitive
// reports toward the link layer and the management entity.
// assumes defect and cell indications are levels from logic on clk; the
// power-good input is a pin and is filtered here.
// What this block does
// - power loss enters power off, error 0, deactive only from operational
// - power return goes silently to power on; leave only on received signal or power loss
// - normal cells restore operational with link active and mgmt activate
// - no signal when off or powering on; cells in three states
// - P-RDI alone moves operational or power on to upstream net fault
// - LOS or LCD enters downstream link fault from every powered state
// - P-AIS enters downstream net fault from four states, error 3
// - P-RDI with S-RDI enters upstream link fault, error 4
// - downstream link fault ignores P-RDI, P-AIS and RDI-pair indications
// - path trace mismatch, when checking is on, acts as LCD
// - every error report names its condition: 0 power, 1 to 4 faults
// - every recovery report names the fault condition that cleared
// - mgmt activate reports recovery and initialisation on return to operational
// - out-of-delineation set on sync to hunt, cleared on presync to sync
`default_nettype none

module ufsm_top
  import ufsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic power_good,
  input wire logic rx_los,
  input wire logic rx_lcd,
  input wire logic trace_check_en,
  input wire logic rx_trace_mismatch,
  input wire logic rx_p_rdi,
  input wire logic rx_s_rdi,
  input wire logic rx_p_ais,
  input wire logic rx_normal_cells,
  input wire logic delin_sync_to_hunt,
  input wire logic delin_presync_to_sync,
  input wire logic delin_lcd_entered,
  output logic ocd_anomaly,
  output ufsm_state_t user_state,
  output ufsm_tx_t tx_mode,
  output logic link_active_ind,
  output logic link_deactive_ind,
  output logic mgmt_activate_ind,
  output logic mgmt_error_ind,
  output logic [UFSM_PARAM_W-1:0] mgmt_error_param,
  output logic mgmt_correction_ind,
  output logic [UFSM_PARAM_W-1:0] mgmt_correction_param
);

  function automatic logic [UFSM_PARAM_W-1:0] pbit(input int unsigned n);
    logic [UFSM_PARAM_W-1:0] v;
    v = UFSM_P_NONE;
    v[n] = 1'b1;
    return v;
  endfunction

  function automatic logic [UFSM_PARAM_W-1:0] cleared(input ufsm_state_t s);
    logic [UFSM_PARAM_W-1:0] v;
    v = UFSM_P_NONE;
    unique case (s)
      UFSM_UPSTREAM_NET_FAULT: v = pbit(UFSM_P_UP_ACCESS);
      UFSM_DOWNSTREAM_LINK_FAULT: v = pbit(UFSM_P_DN_IFACE);
      UFSM_DOWNSTREAM_NET_FAULT: v = pbit(UFSM_P_DN_ACCESS);
      UFSM_UPSTREAM_LINK_FAULT: v = pbit(UFSM_P_UP_IFACE);
      UFSM_DUAL_FAULT: v = pbit(UFSM_P_DN_ACCESS) | pbit(UFSM_P_UP_IFACE);
      UFSM_POWER_OFF, UFSM_OPERATIONAL, UFSM_POWER_ON: v = UFSM_P_NONE;
    endcase
    return v;
  endfunction

  function automatic ufsm_tx_t tx_of(input ufsm_state_t s);
    ufsm_tx_t t;
    t = UFSM_TX_NONE;
    unique case (s)
      UFSM_POWER_OFF, UFSM_POWER_ON: t = UFSM_TX_NONE;
      UFSM_OPERATIONAL, UFSM_UPSTREAM_NET_FAULT, UFSM_UPSTREAM_LINK_FAULT:
        t = UFSM_TX_CELLS;
      UFSM_DOWNSTREAM_LINK_FAULT: t = UFSM_TX_OAM_SRDI_PRDI;
      UFSM_DOWNSTREAM_NET_FAULT, UFSM_DUAL_FAULT: t = UFSM_TX_OAM_PRDI;
    endcase
    return t;
  endfunction

  // power pin filter: change counts once the second and third stages agree
  logic pwr_s1_reg, pwr_s2_reg, pwr_s3_reg, pwr_lvl_reg;
  logic pwr_lvl_next;

  always_comb
  begin
    pwr_lvl_next = pwr_lvl_reg;
    if (pwr_s2_reg == pwr_s3_reg)
    begin
      pwr_lvl_next = pwr_s3_reg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_s1_reg <= UFSM_PWR_RST;
      pwr_s2_reg <= UFSM_PWR_RST;
      pwr_s3_reg <= UFSM_PWR_RST;
      pwr_lvl_reg <= UFSM_PWR_RST;
    end
    else
    begin
      pwr_s1_reg <= power_good;
      pwr_s2_reg <= pwr_s1_reg;
      pwr_s3_reg <= pwr_s2_reg;
      pwr_lvl_reg <= pwr_lvl_next;
    end
  end

  // received indication decode
  logic los_lcd, ind_dual, ind_up_iface, ind_dn_access, ind_up_access, fault_any;

  assign los_lcd = rx_los | rx_lcd | (trace_check_en & rx_trace_mismatch);
  assign ind_dual = rx_p_ais & rx_s_rdi & rx_p_rdi;
  assign ind_up_iface = rx_p_rdi & rx_s_rdi & ~rx_p_ais;
  assign ind_dn_access = rx_p_ais & ~(rx_s_rdi & rx_p_rdi);
  assign ind_up_access = rx_p_rdi & ~rx_s_rdi & ~rx_p_ais;
  assign fault_any = ind_dual | ind_up_iface | ind_dn_access | ind_up_access;

  ufsm_state_t state_reg, state_next, tgt;
  ufsm_tx_t tx_reg, tx_next;
  logic la_reg, la_next, ld_reg, ld_next, ma_reg, ma_next;
  logic ei_reg, ei_next, ci_reg, ci_next, go;
  logic [UFSM_PARAM_W-1:0] ep_reg, ep_next, cp_reg, cp_next, bits;

  always_comb
  begin
    state_next = state_reg;
    la_next = 1'b0;
    ld_next = 1'b0;
    ma_next = 1'b0;
    ep_next = UFSM_P_NONE;
    cp_next = UFSM_P_NONE;
    go = 1'b0;
    tgt = state_reg;
    bits = UFSM_P_NONE;
    if (!pwr_lvl_reg)
    begin
      if (state_reg != UFSM_POWER_OFF)
      begin
        go = 1'b1;
        tgt = UFSM_POWER_OFF;
        bits = pbit(UFSM_P_POWER);
      end
    end
    else if (state_reg == UFSM_POWER_OFF)
    begin
      state_next = UFSM_POWER_ON;
    end
    else if (los_lcd)
    begin
      if (state_reg != UFSM_DOWNSTREAM_LINK_FAULT)
      begin
        go = 1'b1;
        tgt = UFSM_DOWNSTREAM_LINK_FAULT;
        bits = pbit(UFSM_P_DN_IFACE);
      end
    end
    else if (fault_any && state_reg != UFSM_DOWNSTREAM_LINK_FAULT)
    begin
      if (ind_dual)
      begin
        tgt = UFSM_DUAL_FAULT;
        go = (state_reg != UFSM_DUAL_FAULT);
        bits = pbit(UFSM_P_DN_ACCESS) | pbit(UFSM_P_UP_IFACE);
        if (state_reg == UFSM_DOWNSTREAM_NET_FAULT)
        begin
          bits = pbit(UFSM_P_UP_IFACE);
        end
        if (state_reg == UFSM_UPSTREAM_LINK_FAULT)
        begin
          bits = pbit(UFSM_P_DN_ACCESS);
        end
      end
      else if (ind_up_iface)
      begin
        tgt = UFSM_UPSTREAM_LINK_FAULT;
        bits = pbit(UFSM_P_UP_IFACE);
        go = state_reg inside {UFSM_OPERATIONAL, UFSM_UPSTREAM_NET_FAULT,
                               UFSM_DOWNSTREAM_NET_FAULT, UFSM_POWER_ON};
      end
      else if (ind_dn_access)
      begin
        tgt = UFSM_DOWNSTREAM_NET_FAULT;
        bits = pbit(UFSM_P_DN_ACCESS);
        go = state_reg inside {UFSM_OPERATIONAL, UFSM_UPSTREAM_NET_FAULT,
                               UFSM_UPSTREAM_LINK_FAULT, UFSM_POWER_ON};
      end
      else
      begin
        tgt = UFSM_UPSTREAM_NET_FAULT;
        bits = pbit(UFSM_P_UP_ACCESS);
        go = state_reg inside {UFSM_OPERATIONAL, UFSM_POWER_ON};
      end
    end
    else if (rx_normal_cells && state_reg != UFSM_OPERATIONAL)
    begin
      state_next = UFSM_OPERATIONAL;
      la_next = 1'b1;
      ma_next = 1'b1;
      cp_next = cleared(state_reg);
    end
    // a fault seen while a fault indication persists blocks recovery above
    if (go)
    begin
      state_next = tgt;
      ep_next = bits;
      ld_next = (state_reg == UFSM_OPERATIONAL);
    end
    ei_next = |ep_next;
    ci_next = |cp_next;
    tx_next = tx_of(state_next);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= UFSM_STATE_RST;
      tx_reg <= UFSM_TX_RST;
      la_reg <= 1'b0;
      ld_reg <= 1'b0;
      ma_reg <= 1'b0;
      ei_reg <= 1'b0;
      ci_reg <= 1'b0;
      ep_reg <= UFSM_P_NONE;
      cp_reg <= UFSM_P_NONE;
    end
    else
    begin
      state_reg <= state_next;
      tx_reg <= tx_next;
      la_reg <= la_next;
      ld_reg <= ld_next;
      ma_reg <= ma_next;
      ei_reg <= ei_next;
      ci_reg <= ci_next;
      ep_reg <= ep_next;
      cp_reg <= cp_next;
    end
  end

  ufsm_ocd u_ocd (
    .clk(clk),
    .rst(rst),
    .sync_to_hunt(delin_sync_to_hunt),
    .presync_to_sync(delin_presync_to_sync),
    .lcd_entered(delin_lcd_entered),
    .ocd_anomaly(ocd_anomaly)
  );

  assign user_state = state_reg;
  assign tx_mode = tx_reg;
  assign link_active_ind = la_reg;
  assign link_deactive_ind = ld_reg;
  assign mgmt_activate_ind = ma_reg;
  assign mgmt_error_ind = ei_reg;
  assign mgmt_error_param = ep_reg;
  assign mgmt_correction_ind = ci_reg;
  assign mgmt_correction_param = cp_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_powered_fault_free;
    pwr_lvl_reg && !los_lcd && !fault_any;
  endsequence

  sequence s_recovered;
    state_reg == UFSM_OPERATIONAL && link_active_ind && mgmt_activate_ind;
  endsequence

  AST_POWER_LOSS: assert property (
    (!pwr_lvl_reg && state_reg != UFSM_POWER_OFF) |=>
      state_reg == UFSM_POWER_OFF && mgmt_error_ind &&
      mgmt_error_param == pbit(UFSM_P_POWER))
    else $error("power loss not reported as error 0");

  AST_DEACT_SOURCE: assert property (
    link_deactive_ind |-> $past(state_reg) == UFSM_OPERATIONAL)
    else $error("link deactive issued outside operational");

  AST_POWER_RETURN: assert property (
    (pwr_lvl_reg && state_reg == UFSM_POWER_OFF) |=>
      state_reg == UFSM_POWER_ON && !mgmt_error_ind && !mgmt_activate_ind)
    else $error("power return not silent to power on");

  AST_RECOVERY: assert property (
    (s_powered_fault_free ##0 (rx_normal_cells && state_reg != UFSM_POWER_OFF &&
     state_reg != UFSM_OPERATIONAL)) |=> s_recovered)
    else $error("normal cells did not restore operational");

  AST_TX_SILENT: assert property (
    state_reg inside {UFSM_POWER_OFF, UFSM_POWER_ON} |-> tx_mode == UFSM_TX_NONE)
    else $error("transmitting while off or powering on");

  AST_TX_OAM: assert property (
    state_reg == UFSM_DOWNSTREAM_LINK_FAULT |-> tx_mode == UFSM_TX_OAM_SRDI_PRDI)
    else $error("link fault not sending both RDIs");

  AST_UP_ACCESS: assert property (
    (pwr_lvl_reg && !los_lcd && ind_up_access && state_reg == UFSM_OPERATIONAL)
      |=> state_reg == UFSM_UPSTREAM_NET_FAULT && link_deactive_ind &&
      mgmt_error_param == pbit(UFSM_P_UP_ACCESS))
    else $error("upstream access fault mishandled");

  AST_LOS: assert property (
    (pwr_lvl_reg && los_lcd && !(state_reg inside {UFSM_POWER_OFF,
      UFSM_DOWNSTREAM_LINK_FAULT})) |=>
      state_reg == UFSM_DOWNSTREAM_LINK_FAULT &&
      mgmt_error_param == pbit(UFSM_P_DN_IFACE))
    else $error("los or lcd did not enter link fault");

  AST_LINK_HOLD: assert property (
    (pwr_lvl_reg && !los_lcd && state_reg == UFSM_DOWNSTREAM_LINK_FAULT) |=>
      state_reg inside {UFSM_DOWNSTREAM_LINK_FAULT, UFSM_OPERATIONAL})
    else $error("link fault processed a further indication");

  AST_DUAL_FROM_NET: assert property (
    (pwr_lvl_reg && !los_lcd && ind_dual &&
     state_reg == UFSM_DOWNSTREAM_NET_FAULT) |=>
      state_reg == UFSM_DUAL_FAULT && mgmt_error_param == pbit(UFSM_P_UP_IFACE))
    else $error("dual fault entry reported wrong parameters");

  AST_ERR_PARAM: assert property (
    mgmt_error_ind == (mgmt_error_param != UFSM_P_NONE))
    else $error("error report without parameter");

endmodule

`default_nettype wire

// ==== ufsm_pkg.sv ====
// ufsm_pkg: states, transmit modes and primitive parameter positions for
// the user-side layer 1 fault state machine.
// assumes a single 200 MHz clock domain; no timing counts are needed.
`default_nettype none

package ufsm_pkg;

  typedef enum logic [2:0] {
    UFSM_POWER_OFF,
    UFSM_OPERATIONAL,
    UFSM_UPSTREAM_NET_FAULT,
    UFSM_DOWNSTREAM_LINK_FAULT,
    UFSM_DOWNSTREAM_NET_FAULT,
    UFSM_UPSTREAM_LINK_FAULT,
    UFSM_DUAL_FAULT,
    UFSM_POWER_ON
  } ufsm_state_t;

  typedef enum logic [1:0] {
    UFSM_TX_NONE,
    UFSM_TX_CELLS,
    UFSM_TX_OAM_SRDI_PRDI,
    UFSM_TX_OAM_PRDI
  } ufsm_tx_t;

  // width of the parameter vector of error and correction reports, one bit per condition (dual fault sets two, one from downstream net or upstream link fault)
  localparam int unsigned UFSM_PARAM_W = 5;
  // bit positions inside that vector
  localparam int unsigned UFSM_P_POWER = 0;
  localparam int unsigned UFSM_P_UP_ACCESS = 1;
  localparam int unsigned UFSM_P_DN_IFACE = 2;
  localparam int unsigned UFSM_P_DN_ACCESS = 3;
  localparam int unsigned UFSM_P_UP_IFACE = 4;
  localparam logic [UFSM_PARAM_W-1:0] UFSM_P_NONE = 5'h0_0;

  // reset value of the power level filter: powered at reset release
  localparam logic UFSM_PWR_RST = 1'b1;
  localparam ufsm_state_t UFSM_STATE_RST = UFSM_POWER_ON;
  localparam ufsm_tx_t UFSM_TX_RST = UFSM_TX_NONE;

endpackage

`default_nettype wire

// ==== ufsm_ocd.sv ====
// ufsm_ocd: out-of-delineation anomaly flag driven by the delineation
// process transitions.
// assumes the transition strobes are one-cycle pulses on the same clock.
`default_nettype none

module ufsm_ocd
  import ufsm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_to_hunt,
  input wire logic presync_to_sync,
  input wire logic lcd_entered,
  output logic ocd_anomaly
);

  logic ocd_reg;
  logic ocd_next;

  always_comb
  begin
    ocd_next = ocd_reg;
    if (presync_to_sync || lcd_entered)
    begin
      ocd_next = 1'b0;
    end
    // a fresh loss of sync in the clearing cycle must not be lost
    if (sync_to_hunt)
    begin
      ocd_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ocd_reg <= 1'b0;
    end
    else
    begin
      ocd_reg <= ocd_next;
    end
  end

  assign ocd_anomaly = ocd_reg;

  AST_OCD_SET: assert property (@(posedge clk) disable iff (rst)
    sync_to_hunt |=> ocd_anomaly)
    else $error("ocd anomaly not raised after sync to hunt");

  AST_OCD_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (presync_to_sync && !sync_to_hunt) |=> !ocd_anomaly)
    else $error("ocd anomaly not cleared after presync to sync");

endmodule

`default_nettype wire

// ==== ufsm_net_model.sv ====
// ufsm_net_model: behavioural network termination facing the user side;
// a state code from the bench picks what the network sends toward the user.
// assumes the bench changes the code away from the rising clock edge.
`default_nettype none

module ufsm_net_model
(
  input wire logic [2:0] net_code,
  output logic rx_p_rdi,
  output logic rx_s_rdi,
  output logic rx_p_ais,
  output logic rx_normal_cells,
  output logic rx_los,
  output logic net_timing
);
  timeunit 1ns;
  timeprecision 1ps;

  always_comb
  begin
    rx_p_rdi = 1'b0;
    rx_s_rdi = 1'b0;
    rx_p_ais = 1'b0;
    rx_normal_cells = 1'b0;
    rx_los = 1'b0;
    net_timing = 1'b1;
    case (net_code)
      3'h1: rx_normal_cells = 1'b1;
      3'h2: rx_p_rdi = 1'b1;
      3'h3: rx_p_ais = 1'b1;
      3'h4:
      begin
        rx_p_rdi = 1'b1;
        rx_s_rdi = 1'b1;
      end
      3'h5:
      begin
        rx_p_ais = 1'b1;
        rx_s_rdi = 1'b1;
        net_timing = 1'b0;
      end
      3'h6:
      begin
        rx_p_ais = 1'b1;
        rx_s_rdi = 1'b1;
        rx_p_rdi = 1'b1;
      end
      3'h7: rx_los = 1'b1;
      // code 0: line up, idle cells only, no report to make
      default: rx_normal_cells = 1'b0;
    endcase
  end
endmodule

`default_nettype wire

// ==== ufsm_top_test.sv ====
// ufsm_top_test: self-checking bench for the user-side fault state machine.
// assumes ufsm_net_model drives the received indications other than rx_lcd
// and rx_trace_mismatch; pulses are counted between steps so a repeated report would show.
`default_nettype none

module ufsm_top_test
  import ufsm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_good = 1'b1;
  logic rx_lcd = 1'b0;
  logic trace_check_en = 1'b0;
  logic rx_trace_mismatch = 1'b0;
  logic delin_sync_to_hunt = 1'b0;
  logic delin_presync_to_sync = 1'b0;
  logic delin_lcd_entered = 1'b0;
  logic [2:0] net_code = 3'h0;
  logic acc_clr = 1'b1;
  logic rx_p_rdi, rx_s_rdi, rx_p_ais, rx_normal_cells, rx_los, net_timing;
  logic ocd_anomaly, link_active_ind, link_deactive_ind, mgmt_activate_ind;
  logic mgmt_error_ind, mgmt_correction_ind;
  logic [UFSM_PARAM_W-1:0] mgmt_error_param, mgmt_correction_param, err_acc, corr_acc;
  logic [1:0] act_n, deact_n, mact_n, err_n, corr_n;
  ufsm_state_t user_state;
  ufsm_tx_t tx_mode;
  int err_total = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  ufsm_net_model net_u (.net_code(net_code), .rx_p_rdi(rx_p_rdi), .rx_s_rdi(rx_s_rdi),
    .rx_p_ais(rx_p_ais), .rx_normal_cells(rx_normal_cells), .rx_los(rx_los),
    .net_timing(net_timing));

  ufsm_top dut_u (.clk(clk), .rst(rst), .power_good(power_good), .rx_los(rx_los),
    .rx_lcd(rx_lcd), .trace_check_en(trace_check_en),
    .rx_trace_mismatch(rx_trace_mismatch), .rx_p_rdi(rx_p_rdi), .rx_s_rdi(rx_s_rdi),
    .rx_p_ais(rx_p_ais), .rx_normal_cells(rx_normal_cells),
    .delin_sync_to_hunt(delin_sync_to_hunt), .delin_presync_to_sync(delin_presync_to_sync),
    .delin_lcd_entered(delin_lcd_entered), .ocd_anomaly(ocd_anomaly),
    .user_state(user_state), .tx_mode(tx_mode), .link_active_ind(link_active_ind),
    .link_deactive_ind(link_deactive_ind), .mgmt_activate_ind(mgmt_activate_ind),
    .mgmt_error_ind(mgmt_error_ind), .mgmt_error_param(mgmt_error_param),
    .mgmt_correction_ind(mgmt_correction_ind),
    .mgmt_correction_param(mgmt_correction_param));

  // pulses are tallied, not sampled once, so a second report is caught
  always @(posedge clk)
  begin
    if (acc_clr)
    begin
      {act_n, deact_n, mact_n, err_n, corr_n} <= 10'h000;
      {err_acc, corr_acc} <= 10'h000;
    end
    else
    begin
      act_n <= act_n + 2'(link_active_ind);
      deact_n <= deact_n + 2'(link_deactive_ind);
      mact_n <= mact_n + 2'(mgmt_activate_ind);
      err_n <= err_n + 2'(mgmt_error_ind);
      corr_n <= corr_n + 2'(mgmt_correction_ind);
      if (mgmt_error_ind)
        err_acc <= err_acc | mgmt_error_param;
      if (mgmt_correction_ind)
        corr_acc <= corr_acc | mgmt_correction_param;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // in_v: bit 3 is rx_lcd, bits 2:0 the network code; adm is act, deact, mgmt act
  task automatic go(input logic [3:0] in_v, input int cyc, input ufsm_state_t st,
    input ufsm_tx_t tx, input logic [2:0] adm, input logic [4:0] ep, input logic [4:0] cp);
    logic [24:0] exp_v;
    rx_lcd = in_v[3];
    net_code = in_v[2:0];
    acc_clr = 1'b1;
    @(negedge clk);
    acc_clr = 1'b0;
    repeat (cyc - 1) @(negedge clk);
    exp_v = {st, tx, 1'b0, adm[2], 1'b0, adm[1], 1'b0, adm[0], 1'b0, |ep, ep, 1'b0, |cp, cp};
    check({7'h00, user_state, tx_mode, act_n, deact_n, mact_n, err_n, err_acc, corr_n,
      corr_acc}, {7'h00, exp_v});
  endtask

  task automatic ocd_pulse(input logic [2:0] p, input logic want);
    {delin_sync_to_hunt, delin_presync_to_sync, delin_lcd_entered} = p;
    @(negedge clk);
    {delin_sync_to_hunt, delin_presync_to_sync, delin_lcd_entered} = 3'h0;
    check({31'h0000_0000, ocd_anomaly}, {31'h0000_0000, want});
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    go(4'h0, 3, UFSM_POWER_ON, UFSM_TX_NONE, 3'h0, 5'h00, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h0, 5'h00, 5'h00);
    go(4'h2, 3, UFSM_UPSTREAM_NET_FAULT, UFSM_TX_CELLS, 3'h2, 5'h02, 5'h00);
    go(4'h5, 3, UFSM_DOWNSTREAM_NET_FAULT, UFSM_TX_OAM_PRDI, 3'h0, 5'h08, 5'h00);
    check({31'h0000_0000, net_timing}, 32'h0000_0000);
    go(4'h4, 3, UFSM_UPSTREAM_LINK_FAULT, UFSM_TX_CELLS, 3'h0, 5'h10, 5'h00);
    go(4'h6, 3, UFSM_DUAL_FAULT, UFSM_TX_OAM_PRDI, 3'h0, 5'h08, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h18);
    go(4'h3, 3, UFSM_DOWNSTREAM_NET_FAULT, UFSM_TX_OAM_PRDI, 3'h2, 5'h08, 5'h00);
    go(4'h6, 3, UFSM_DUAL_FAULT, UFSM_TX_OAM_PRDI, 3'h0, 5'h10, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h18);
    $display("test fault entry done");
    go(4'h9, 3, UFSM_DOWNSTREAM_LINK_FAULT, UFSM_TX_OAM_SRDI_PRDI, 3'h2, 5'h04, 5'h00);
    go(4'h6, 3, UFSM_DOWNSTREAM_LINK_FAULT, UFSM_TX_OAM_SRDI_PRDI, 3'h0, 5'h00, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h04);
    go(4'hB, 3, UFSM_DOWNSTREAM_LINK_FAULT, UFSM_TX_OAM_SRDI_PRDI, 3'h2, 5'h04, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h04);
    go(4'h6, 3, UFSM_DUAL_FAULT, UFSM_TX_OAM_PRDI, 3'h2, 5'h18, 5'h00);
    go(4'h2, 3, UFSM_DUAL_FAULT, UFSM_TX_OAM_PRDI, 3'h0, 5'h00, 5'h00);
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h18);
    $display("test link fault and priority done");
    trace_check_en = 1'b1;
    rx_trace_mismatch = 1'b1;
    go(4'h1, 3, UFSM_DOWNSTREAM_LINK_FAULT, UFSM_TX_OAM_SRDI_PRDI, 3'h2, 5'h04, 5'h00);
    rx_trace_mismatch = 1'b0;
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h5, 5'h00, 5'h04);
    trace_check_en = 1'b0;
    rx_trace_mismatch = 1'b1;
    go(4'h1, 3, UFSM_OPERATIONAL, UFSM_TX_CELLS, 3'h0, 5'h00, 5'h00);
    rx_trace_mismatch = 1'b0;
    $display("test path trace done");
    power_good = 1'b0;
    go(4'h1, 7, UFSM_POWER_OFF, UFSM_TX_NONE, 3'h2, 5'h01, 5'h00);
    power_good = 1'b1;
    go(4'h0, 8, UFSM_POWER_ON, UFSM_TX_NONE, 3'h0, 5'h00, 5'h00);
    power_good = 1'b0;
    go(4'h0, 7, UFSM_POWER_OFF, UFSM_TX_NONE, 3'h0, 5'h01, 5'h00);
    power_good = 1'b1;
    go(4'h0, 8, UFSM_POWER_ON, UFSM_TX_NONE, 3'h0, 5'h00, 5'h00);
    go(4'h2, 3, UFSM_UPSTREAM_NET_FAULT, UFSM_TX_CELLS, 3'h0, 5'h02, 5'h00);
    go(4'h7, 3, UFSM_DOWNSTREAM_LINK_FAULT, UFSM_TX_OAM_SRDI_PRDI, 3'h0, 5'h04, 5'h00);
    $display("test power done");
    ocd_pulse(3'h4, 1'b1);
    ocd_pulse(3'h2, 1'b0);
    ocd_pulse(3'h4, 1'b1);
    ocd_pulse(3'h1, 1'b0);
    ocd_pulse(3'h6, 1'b1);
    $display("test delineation done");
    end_sim();
  end
endmodule

`default_nettype wire
